// File: core/mcu_address_decode_paging.sv
// address decode, paging and latched address output front end
// Notes on behaviour
// [RULE1] main flash: eight sectors, own selects
// [RULE2] secondary memory: four sectors, own selects
// [RULE3] scratchpad sram gets its own select
// [RULE4] every sector placed independently by parameters
// [RULE5] seventeen selects from forty-two product terms
// [RULE6] selects purely combinational from terms
// [RULE7] one input bus shared with user logic
// [RULE8] bus strobes also feed the logic inputs
// [RULE9] eight-bit page extends addresses for decode
// [RULE10] page changes remap flash sector blocks
// [RULE11] 256-byte register window at chosen base
// [RULE12] 8-bit multiplexed host: ports show latched address
// [RULE13] low nibble a3-a0, high a7-a4
// [RULE14] ports a/b as data or 16-bit bus
// [RULE15] host strobe captures multiplexed address
// [RULE16] chip select high disables memory selects
// [RULE17] window select on base match, low byte indexes
// [RULE18] host writes page before dependent accesses
`timescale 1ns/1ns
module mcu_address_decode_paging
    import addr_decode_pkg::*;
#(
    parameter logic [15:0] WINDOW_BASE = WINDOW_BASE_DEFAULT,
    parameter logic [NUM_TERMS*IBUS_W-1:0] TERM_VALUES = '0,
    parameter logic [NUM_TERMS*IBUS_W-1:0] TERM_MASKS = '0,
    parameter logic [NUM_TERMS-1:0] TERM_ENABLES = '0,
    parameter bit USE_DEFAULT_MAP = 1'b1
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [2:0] bus_mode,
    input wire logic port_a_addr_out_en,
    input wire logic port_b_addr_out_en,
    input wire logic address_latch_strobe,
    input wire logic rd_b,
    input wire logic wr_b,
    input wire logic chip_sel_in_b,
    input wire logic [7:0] ad_in,
    output logic [7:0] ad_out,
    output logic ad_oe_b,
    input wire logic [7:0] addr_hi_in,
    input wire logic [7:0] port_a_in,
    output logic [7:0] port_a_out,
    output logic port_a_oe_b,
    input wire logic [7:0] port_b_in,
    output logic [7:0] port_b_out,
    output logic port_b_oe_b,
    output logic [NUM_FLASH_SEL-1:0] flash_sel,
    output logic [NUM_SEC_SEL-1:0] sec_sel,
    output logic sram_sel,
    output logic register_window_select,
    output logic [NUM_PERIPH_SEL-1:0] periph_sel,
    output logic [7:0] reg_index,
    output logic [IBUS_W-1:0] pld_input_bus
);

    // reset release through two flops
    logic rst_meta_q;
    logic rst_sync_q;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // two-flop synchronisers for every pin input
    localparam int SYNC_W = 3 + 2 + 4 + 8 + 8 + 8 + 8;
    logic [SYNC_W-1:0] pins_raw;
    logic [SYNC_W-1:0] pins_meta_q;
    logic [SYNC_W-1:0] pins_q;
    assign pins_raw = {bus_mode, port_a_addr_out_en, port_b_addr_out_en, address_latch_strobe,
                       rd_b, wr_b, chip_sel_in_b, ad_in, addr_hi_in, port_a_in, port_b_in};
    always_ff @(posedge clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            pins_meta_q <= '1;
            pins_q <= '1;
        end else begin
            pins_meta_q <= pins_raw;
            pins_q <= pins_meta_q;
        end
    end

    // named views of synchronised pins
    wire logic [2:0] mode_s = pins_q[SYNC_W-1 -: 3];
    wire logic pa_addr_en_s = pins_q[SYNC_W-4];
    wire logic pb_addr_en_s = pins_q[SYNC_W-5];
    wire logic strobe_s = pins_q[35];
    wire logic rd_b_s = pins_q[34];
    wire logic wr_b_s = pins_q[33];
    wire logic cs_b_s = pins_q[32];
    wire logic [7:0] ad_s = pins_q[31:24];
    wire logic [7:0] hi_s = pins_q[23:16];
    wire logic [7:0] pa_s = pins_q[15:8];
    wire logic [7:0] pb_s = pins_q[7:0];

    // mode decode
    wire logic mode_mux8 = (mode_s == BUS_MUX8);
    wire logic mode_nonmux = (mode_s == BUS_NONMUX8);
    wire logic mode_mux16 = (mode_s == BUS_MUX16);
    wire logic addr_is_muxed = mode_mux8 || mode_mux16; // [RULE12]

    // address phase source and latch
    logic [7:0] addr_lo_q;
    logic [7:0] addr_hi_q;
    wire logic [7:0] lo_src = mode_mux16 ? pa_s : ad_s; // [RULE14]
    wire logic [7:0] hi_src = mode_mux16 ? pb_s : hi_s;
    always_ff @(posedge clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            addr_lo_q <= 8'h00;
            addr_hi_q <= 8'h00;
        end else if (strobe_s) begin
            addr_lo_q <= lo_src; // [RULE15]
            addr_hi_q <= hi_src;
        end
    end

    // effective address seen by the decoder
    wire logic [7:0] addr_lo = addr_is_muxed ? addr_lo_q : ad_s;
    wire logic [7:0] addr_hi = mode_mux16 ? addr_hi_q : hi_s;
    wire logic [15:0] addr_full = {addr_hi, addr_lo};

    // page register
    logic [7:0] page_q;

    // shared input bus: page, address, bus strobes, chip select
    assign pld_input_bus = {page_q, addr_full, rd_b_s, wr_b_s, strobe_s, cs_b_s}; // [RULE7] [RULE8] [RULE9]

    // product term array
    logic [NUM_TERMS-1:0] term_hit;
    localparam logic [NUM_TERMS-1:0] DEFAULT_ENABLES = term_enables();
    genvar t;
    generate
        for (t = 0; t < NUM_TERMS; t++) begin : g_term
            localparam logic [IBUS_W-1:0] TV = USE_DEFAULT_MAP ? term_value(t, WINDOW_BASE)
                                                               : TERM_VALUES[t*IBUS_W +: IBUS_W];
            localparam logic [IBUS_W-1:0] TM = USE_DEFAULT_MAP ? term_mask(t)
                                                               : TERM_MASKS[t*IBUS_W +: IBUS_W];
            localparam bit TE = USE_DEFAULT_MAP ? DEFAULT_ENABLES[t] : TERM_ENABLES[t];
            decode_term #(.VALUE(TV), .MASK(TM), .ENABLE(TE)) u_term ( // [RULE4] [RULE10]
                .ibus(pld_input_bus),
                .hit(term_hit[t])
            );
        end
    endgenerate

    // or the terms into seventeen selects, gated by chip select
    logic [NUM_SEL-1:0] sel_raw;
    genvar o;
    generate
        for (o = 0; o < NUM_SEL; o++) begin : g_sel
            logic [NUM_TERMS-1:0] feed;
            for (genvar k = 0; k < NUM_TERMS; k++) begin : g_feed
                assign feed[k] = (term_output(k) == o) ? term_hit[k] : 1'b0;
            end
            assign sel_raw[o] = (|feed) && !cs_b_s; // [RULE5] [RULE6] [RULE16]
        end
    endgenerate

    // select outputs
    assign flash_sel = sel_raw[NUM_FLASH_SEL-1:0]; // [RULE1]
    assign sec_sel = sel_raw[NUM_FLASH_SEL +: NUM_SEC_SEL]; // [RULE2]
    assign sram_sel = sel_raw[SEL_SRAM]; // [RULE3]
    assign register_window_select = sel_raw[SEL_WINDOW]; // [RULE11] [RULE17]
    assign periph_sel = sel_raw[SEL_PERIPH +: NUM_PERIPH_SEL];
    assign reg_index = addr_lo; // [RULE17]

    // register write and read qualification
    logic wr_b_d1_q;
    always_ff @(posedge clk or negedge rst_sync_q) begin
        if (!rst_sync_q)
            wr_b_d1_q <= 1'b1;
        else
            wr_b_d1_q <= wr_b_s;
    end
    wire logic page_hit = register_window_select && (addr_lo == OFS_PAGE);
    wire logic wr_fall = wr_b_d1_q && !wr_b_s;
    wire logic [7:0] wdata = mode_mux8 ? ad_s : pa_s;
    wire logic page_wr = page_hit && wr_fall;
    wire logic win_rd = register_window_select && !rd_b_s;

    // page register update
    always_ff @(posedge clk or negedge rst_sync_q) begin
        if (!rst_sync_q)
            page_q <= PAGE_RESET;
        else if (page_wr)
            page_q <= wdata; // [RULE9] [RULE18]
    end

    // read data register; unmodelled offsets read zero
    logic [7:0] rdata_q;
    logic win_rd_q;
    always_ff @(posedge clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            rdata_q <= 8'h00;
            win_rd_q <= 1'b0;
        end else begin
            rdata_q <= page_hit ? page_q : 8'h00;
            win_rd_q <= win_rd;
        end
    end

    // latched address and data drive on the pins
    logic [7:0] pa_out_q;
    logic [7:0] pb_out_q;
    wire logic pa_as_addr = pa_addr_en_s && mode_mux8; // [RULE13]
    wire logic pb_as_addr = pb_addr_en_s && (mode_mux8 || mode_nonmux); // [RULE13]
    wire logic pa_as_data = (mode_nonmux || mode_mux16) && win_rd_q; // [RULE14]
    always_ff @(posedge clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            pa_out_q <= 8'h00;
            pb_out_q <= 8'h00;
        end else begin
            pa_out_q <= pa_as_addr ? addr_lo : rdata_q;
            pb_out_q <= addr_lo; // [RULE12]
        end
    end

    assign ad_out = rdata_q;
    assign ad_oe_b = !(mode_mux8 && win_rd_q && rst_sync_q);
    assign port_a_out = pa_out_q;
    assign port_a_oe_b = !((pa_as_addr || pa_as_data) && rst_sync_q);
    assign port_b_out = pb_out_q;
    assign port_b_oe_b = !(pb_as_addr && rst_sync_q);

endmodule

// File: core/addr_decode_pkg.sv
// constants for the address decode and paging front end
package addr_decode_pkg;

    localparam int PAGE_W = 8;
    localparam int ADDR_W = 16;
    localparam int STROBE_W = 4;
    localparam int IBUS_W = PAGE_W + ADDR_W + STROBE_W;

    // input bus field positions: {page, address, rd, wr, latch strobe, chip select}
    localparam int IB_CS = 0;
    localparam int IB_STB = 1;
    localparam int IB_WR = 2;
    localparam int IB_RD = 3;
    localparam int IB_ADDR_LSB = 4;
    localparam int IB_PAGE_LSB = IB_ADDR_LSB + ADDR_W;

    // decode array shape
    localparam int NUM_FLASH_SEL = 8;
    localparam int NUM_SEC_SEL = 4;
    localparam int NUM_PERIPH_SEL = 3;
    localparam int NUM_SEL = 17;
    localparam int NUM_TERMS = 42;
    localparam int TERMS_PER_SECTOR = 3;
    localparam int SEL_SRAM = NUM_FLASH_SEL + NUM_SEC_SEL;
    localparam int SEL_WINDOW = SEL_SRAM + 1;
    localparam int SEL_PERIPH = SEL_WINDOW + 1;
    localparam int TERM_SEC0 = NUM_FLASH_SEL * TERMS_PER_SECTOR;
    localparam int TERM_SRAM = TERM_SEC0 + NUM_SEC_SEL * TERMS_PER_SECTOR;
    localparam int TERM_WINDOW = TERM_SRAM + 1;
    localparam int TERM_PERIPH = TERM_WINDOW + 1;

    // register window
    localparam logic [7:0] OFS_PAGE = 8'hE0;
    localparam logic [7:0] PAGE_RESET = 8'h00;
    localparam logic [15:0] WINDOW_BASE_DEFAULT = 16'hD000;

    // default memory map
    localparam logic [15:0] FLASH_BASE = 16'h8000;
    localparam logic [15:0] SEC_BASE = 16'h0000;
    localparam logic [15:0] SRAM_BASE = 16'hC000;
    localparam logic [15:0] PERIPH_BASE = 16'hE000;

    // host bus arrangements
    typedef enum logic [2:0] {
        BUS_MUX8 = 3'b001,
        BUS_NONMUX8 = 3'b010,
        BUS_MUX16 = 3'b100
    } bus_mode_e;

    // which select each product term feeds
    function automatic int term_output(input int t);
        if (t < TERM_SRAM)
            return t / TERMS_PER_SECTOR;
        else if (t == TERM_SRAM)
            return SEL_SRAM;
        else if (t == TERM_WINDOW)
            return SEL_WINDOW;
        else if (t < NUM_TERMS - 1)
            return SEL_PERIPH + t - TERM_PERIPH;
        else
            return SEL_PERIPH + NUM_PERIPH_SEL - 1;
    endfunction

    // default compare value per term
    function automatic logic [IBUS_W-1:0] term_value(input int t, input logic [15:0] win_base);
        logic [IBUS_W-1:0] v;
        v = '0;
        if (t < TERM_SEC0) begin
            v[IB_PAGE_LSB +: PAGE_W] = 8'(t / TERMS_PER_SECTOR);
            v[IB_ADDR_LSB +: ADDR_W] = FLASH_BASE;
        end else if (t < TERM_SRAM) begin
            v[IB_ADDR_LSB +: ADDR_W] = SEC_BASE | 16'(((t - TERM_SEC0) / TERMS_PER_SECTOR) << 13);
        end else if (t == TERM_SRAM) begin
            v[IB_ADDR_LSB +: ADDR_W] = SRAM_BASE;
        end else if (t == TERM_WINDOW) begin
            v[IB_ADDR_LSB +: ADDR_W] = win_base;
        end else begin
            v[IB_ADDR_LSB +: ADDR_W] = PERIPH_BASE | 16'((t - TERM_PERIPH) << 8);
        end
        return v;
    endfunction

    // default care mask per term (1 = bit compared)
    function automatic logic [IBUS_W-1:0] term_mask(input int t);
        logic [IBUS_W-1:0] m;
        m = '0;
        if (t < TERM_SEC0) begin
            m[IB_PAGE_LSB +: PAGE_W] = 8'hFF;
            m[IB_ADDR_LSB +: ADDR_W] = 16'hC000;
        end else if (t < TERM_SRAM) begin
            m[IB_ADDR_LSB +: ADDR_W] = 16'hE000;
        end else if (t == TERM_SRAM) begin
            m[IB_ADDR_LSB +: ADDR_W] = 16'hF800;
        end else begin
            m[IB_ADDR_LSB +: ADDR_W] = 16'hFF00;
        end
        return m;
    endfunction

    // default term enables: first term of each sector, every term from sram on except the last
    function automatic logic [NUM_TERMS-1:0] term_enables();
        logic [NUM_TERMS-1:0] e;
        e = '0;
        for (int t = 0; t < NUM_TERMS; t++) begin
            if (t >= TERM_SRAM || (t % TERMS_PER_SECTOR) == 0)
                e[t] = 1'b1;
        end
        e[NUM_TERMS-1] = 1'b0;
        return e;
    endfunction

endpackage

// File: core/decode_term.sv
// one product term of the address decode array
`timescale 1ns/1ns
module decode_term
    import addr_decode_pkg::*;
#(
    parameter logic [IBUS_W-1:0] VALUE = '0,
    parameter logic [IBUS_W-1:0] MASK = '0,
    parameter bit ENABLE = 1'b1
) (
    input wire logic [IBUS_W-1:0] ibus,
    output logic hit
);

    // masked compare, no storage
    assign hit = ENABLE && (((ibus ^ VALUE) & MASK) == '0);

endmodule

// File: verif/mcu_host_model.sv
// host microcontroller model on the multiplexed 8-bit bus
`timescale 1ns/1ns
module mcu_host_model (
    input wire logic clk,
    input wire logic [7:0] ad_out,
    input wire logic ad_oe_b,
    input wire logic [7:0] port_a_out,
    input wire logic port_a_oe_b,
    output logic address_latch_strobe,
    output logic rd_b,
    output logic wr_b,
    output logic [7:0] ad_in,
    output logic [7:0] addr_hi_in
);
    // idle bus at time zero
    initial begin
        address_latch_strobe = 1'b0;
        rd_b = 1'b1;
        wr_b = 1'b1;
        ad_in = 8'h00;
        addr_hi_in = 8'h00;
    end

    // address phase, then the bus moves on to nxt
    task automatic put_addr(input logic [15:0] a, input logic [7:0] nxt);
        @(negedge clk);
        ad_in = a[7:0];
        addr_hi_in = a[15:8];
        address_latch_strobe = 1'b1;
        repeat (3) @(negedge clk);
        address_latch_strobe = 1'b0;
        repeat (2) @(negedge clk);
        ad_in = nxt;
    endtask

    // write cycle: data on the bus while the write strobe is low
    task automatic bus_write(input logic [15:0] a, input logic [7:0] d);
        put_addr(a, d);
        wr_b = 1'b0;
        repeat (5) @(negedge clk);
        wr_b = 1'b1;
        repeat (3) @(negedge clk);
        ad_in = ~d;
    endtask

    // read cycle: bounded wait for the device to drive the bus
    task automatic bus_read(input logic [15:0] a, output logic [7:0] d);
        int n;
        put_addr(a, ~a[7:0]);
        rd_b = 1'b0;
        n = 0;
        while (ad_oe_b !== 1'b0 && n < 20) begin
            @(negedge clk);
            n++;
        end
        d = (n < 20) ? ad_out : 8'hXX;
        rd_b = 1'b1;
        repeat (3) @(negedge clk);
    endtask

    // non-multiplexed cycle: address held flat, data on port A
    task automatic flat_cycle(input logic [15:0] a, input logic is_wr, output logic [7:0] d);
        put_addr(a, a[7:0]);
        if (is_wr)
            wr_b = 1'b0;
        else
            rd_b = 1'b0;
        repeat (6) @(negedge clk);
        d = (port_a_oe_b === 1'b0) ? port_a_out : 8'hXX;
        wr_b = 1'b1;
        rd_b = 1'b1;
        repeat (3) @(negedge clk);
    endtask
endmodule

// File: verif/decode_checker.sv
// port assertions for the address decode front end
`timescale 1ns/1ns
module decode_checker
    import addr_decode_pkg::*;
#(
    parameter logic [15:0] WINDOW_BASE = WINDOW_BASE_DEFAULT
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [NUM_FLASH_SEL-1:0] flash_sel,
    input wire logic [NUM_SEC_SEL-1:0] sec_sel,
    input wire logic sram_sel,
    input wire logic register_window_select,
    input wire logic [NUM_PERIPH_SEL-1:0] periph_sel,
    input wire logic [7:0] reg_index,
    input wire logic [IBUS_W-1:0] pld_input_bus
);
    // fields of the shared input bus
    wire logic cs_b = pld_input_bus[IB_CS];
    wire logic [15:0] a = pld_input_bus[IB_ADDR_LSB +: ADDR_W];
    wire logic [7:0] pg = pld_input_bus[IB_PAGE_LSB +: PAGE_W];
    wire logic wsel_e0 = register_window_select && reg_index == OFS_PAGE;
    wire logic [16:0] sels = {flash_sel, sec_sel, sram_sel, register_window_select, periph_sel};

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    AST_CS_OFF: assert property (cs_b |-> sels == 17'h00000)
        else $error("select active while chip select high");
    AST_FLASH: assert property (!cs_b |-> flash_sel == ((a[15:14] == 2'b10 && pg < 8'h08) ? 8'h01 << pg[2:0] : 8'h00))
        else $error("flash select does not follow page and address");
    AST_SEC: assert property (!cs_b |-> sec_sel == (a[15] ? 4'h0 : 4'h1 << a[14:13]))
        else $error("secondary select wrong");
    AST_SRAM: assert property (sram_sel == (!cs_b && a[15:11] == 5'h18))
        else $error("sram select wrong");
    AST_WIN: assert property (register_window_select == (!cs_b && a[15:8] == WINDOW_BASE[15:8]))
        else $error("window select wrong");
    AST_INDEX: assert property (register_window_select |-> reg_index == a[7:0])
        else $error("register index differs from low address");
    AST_COMB: assert property ($stable(pld_input_bus) |-> $stable(sels))
        else $error("select moved with input bus stable");
    AST_PAGE: assert property ($changed(pg) |-> $past(wsel_e0) || $past(wsel_e0, 2))
        else $error("page changed without a window access");

    COV_FLASH7: cover property (flash_sel[7]);
    COV_PAGE: cover property (wsel_e0);
    COV_CS: cover property (cs_b ##1 !cs_b);
endmodule

bind mcu_address_decode_paging decode_checker #(.WINDOW_BASE(WINDOW_BASE)) decode_checker_inst (.clk, .rst_b,
    .flash_sel, .sec_sel, .sram_sel, .register_window_select, .periph_sel, .reg_index, .pld_input_bus);

// File: verif/testbench.sv
// self-checking bench for the address decode and paging front end
`timescale 1ns/1ns
module testbench
    import addr_decode_pkg::*;
;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [2:0] bus_mode = BUS_MUX8;
    logic port_a_addr_out_en = 1'b1;
    logic port_b_addr_out_en = 1'b1;
    logic chip_sel_in_b = 1'b0;
    logic [7:0] port_a_in = 8'h00;
    logic [7:0] port_b_in = 8'h00;
    logic address_latch_strobe, rd_b, wr_b, ad_oe_b, port_a_oe_b, port_b_oe_b;
    logic sram_sel, register_window_select;
    logic [7:0] ad_in, addr_hi_in, ad_out, port_a_out, port_b_out, reg_index, flash_sel, rd;
    logic [3:0] sec_sel;
    logic [2:0] periph_sel;
    logic [IBUS_W-1:0] pld_input_bus;
    int n_fail = 0;
    int check_count = 0;

    // 20 MHz clock
    always #25 clk = ~clk;

    mcu_address_decode_paging mcu_address_decode_paging_inst (.clk, .rst_b, .bus_mode, .port_a_addr_out_en,
        .port_b_addr_out_en, .address_latch_strobe, .rd_b, .wr_b, .chip_sel_in_b, .ad_in, .ad_out, .ad_oe_b,
        .addr_hi_in, .port_a_in, .port_a_out, .port_a_oe_b, .port_b_in, .port_b_out,
        .port_b_oe_b, .flash_sel, .sec_sel, .sram_sel, .register_window_select, .periph_sel, .reg_index,
        .pld_input_bus);
    mcu_host_model mcu_host_model_inst (.clk, .ad_out, .ad_oe_b, .port_a_out, .port_a_oe_b,
        .address_latch_strobe, .rd_b, .wr_b, .ad_in, .addr_hi_in);

    task automatic check_val(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // latch an address, let it settle, compare all selects; ot = {sram, window, periph}
    task automatic sel_at(input logic [15:0] a, input logic [7:0] fl, input logic [3:0] sc, input logic [4:0] ot);
        mcu_host_model_inst.put_addr(a, ~a[7:0]);
        repeat (3) @(negedge clk);
        check_val("flash_sel", fl, flash_sel);
        check_val("sec_sel", {4'h0, sc}, {4'h0, sec_sel});
        check_val("other_sel", {3'h0, ot}, {3'h0, sram_sel, register_window_select, periph_sel});
    endtask

    task automatic tally_and_finish();
        if (n_fail == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (10) @(negedge clk);
        rst_b = 1'b1;
        repeat (4) @(negedge clk);
        mcu_host_model_inst.bus_read(16'hD0E0, rd);
        check_val("page reset", PAGE_RESET, rd);
        for (int p = 0; p < 9; p++) begin
            mcu_host_model_inst.bus_write(16'hD0E0, 8'(p));
            mcu_host_model_inst.bus_read(16'hD0E0, rd);
            check_val("page", 8'(p), rd);
            sel_at(16'h8000 + 16'(p) * 16'h07FF, (p < 8) ? 8'h01 << p : 8'h00, 4'h0, 5'h00);
        end
        for (int j = 0; j < 4; j++)
            sel_at(16'(j) * 16'h2000 + 16'h1FFF, 8'h00, 4'h1 << j, 5'h00);
        sel_at(16'hC7FF, 8'h00, 4'h0, 5'h10);
        sel_at(16'hC800, 8'h00, 4'h0, 5'h00);
        sel_at(16'hD0FF, 8'h00, 4'h0, 5'h08);
        check_val("reg_index", 8'hFF, reg_index);
        sel_at(16'hD100, 8'h00, 4'h0, 5'h00);
        for (int k = 0; k < 3; k++)
            sel_at(16'hE042 + 16'(k) * 16'h0100, 8'h00, 4'h0, 5'(1 << k));
        mcu_host_model_inst.bus_write(16'hD010, 8'h5A);
        mcu_host_model_inst.bus_read(16'hD010, rd);
        check_val("unmapped read", 8'h00, rd);
        mcu_host_model_inst.bus_read(16'hD0E0, rd);
        check_val("page kept", 8'h08, rd);
        sel_at(16'h12A5, 8'h00, 4'h1, 5'h00);
        check_val("port_a addr", 8'hA5, port_a_out);
        check_val("port_b addr", 8'hA5, port_b_out);
        check_val("port oe", 8'h00, {6'h0, port_a_oe_b, port_b_oe_b});
        check_val("bus strobes", 8'h0C, {4'h0, pld_input_bus[3:0]});
        check_val("bus addr", 8'hA5, pld_input_bus[IB_ADDR_LSB +: 8]);
        check_val("bus page", 8'h08, pld_input_bus[IB_PAGE_LSB +: 8]);
        // non-multiplexed host: address held flat, data on port A
        bus_mode = BUS_NONMUX8;
        port_a_in = 8'h03;
        mcu_host_model_inst.flat_cycle(16'hD0E0, 1'b1, rd);
        port_a_in = 8'h00;
        mcu_host_model_inst.flat_cycle(16'hD0E0, 1'b0, rd);
        check_val("nonmux page", 8'h03, rd);
        mcu_host_model_inst.flat_cycle(16'h8123, 1'b0, rd);
        check_val("nonmux flash_sel", 8'h08, flash_sel);
        check_val("nonmux port_b addr", 8'h23, port_b_out);
        check_val("nonmux port oe", 8'h02, {6'h0, port_a_oe_b, port_b_oe_b});
        // 16-bit host: address latched from ports A and B, then A moves on
        bus_mode = BUS_MUX16;
        port_a_in = 8'h23;
        port_b_in = 8'hC1;
        mcu_host_model_inst.put_addr(16'h0000, 8'h00);
        port_a_in = 8'h55;
        repeat (3) @(negedge clk);
        check_val("mux16 sram", 8'h01, {7'h0, sram_sel});
        check_val("mux16 index", 8'h23, reg_index);
        check_val("mux16 oe", 8'h03, {6'h0, port_a_oe_b, port_b_oe_b});
        bus_mode = BUS_MUX8;
        chip_sel_in_b = 1'b1;
        sel_at(16'hD0E0, 8'h00, 4'h0, 5'h00);
        chip_sel_in_b = 1'b0;
        sel_at(16'hC000, 8'h00, 4'h0, 5'h10);
        // mid-run reset: page returns to its reset value
        rst_b = 1'b0;
        repeat (10) @(negedge clk);
        rst_b = 1'b1;
        repeat (4) @(negedge clk);
        mcu_host_model_inst.bus_read(16'hD0E0, rd);
        check_val("page after reset", PAGE_RESET, rd);
        tally_and_finish();
    end

    // watchdog against a hung handshake
    initial begin
        #(50 * 40000);
        n_fail++;
        tally_and_finish();
    end
endmodule
